// file: hw/tfs_pkg.sv
/*
  Package for the thermal/fan status readout: register offsets, bit positions,
  reset values and widths shared by the status bank and its helpers.
  Assumes a host-side byte read port with an 8-bit register address.
*/
package tfs_pkg;
  // register offsets
  localparam logic [7:0] OFS_STATUS_PRIMARY = 8'h02;
  localparam logic [7:0] OFS_STATUS_SECONDARY = 8'h03;
  localparam logic [7:0] OFS_TEMP_FRACTION = 8'h06;
  localparam logic [7:0] OFS_FAN_PERIOD = 8'h08;
  localparam logic [7:0] OFS_LOCAL_TEMP = 8'h0a;
  localparam logic [7:0] OFS_REMOTE_TEMP = 8'h0b;
  // primary status bit positions
  localparam int BIT_LOCAL_LOW = 7;
  localparam int BIT_LOCAL_HIGH = 6;
  localparam int BIT_DIODE_ERR = 5;
  localparam int BIT_REMOTE_ALARM = 4;
  localparam int BIT_REMOTE_LOW = 3;
  localparam int BIT_REMOTE_HIGH = 2;
  localparam int BIT_FULL_DUTY = 1;
  // secondary status bit positions
  localparam int BIT_LINE_PULLED = 7;
  localparam int BIT_LOCAL_ALARM = 6;
  // fraction register field positions
  localparam int FRAC_LOCAL_LSB = 5;
  localparam int FRAC_REMOTE_LSB = 0;
  localparam int FRAC_WIDTH = 3;
  // reset values
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_FRACTION = 8'h00;
  localparam logic [7:0] RST_FAN_PERIOD = 8'hff;
  localparam logic [7:0] RST_TEMP = 8'h1e;
  localparam logic [7:0] RST_TACH_LIMIT = 8'hff;
  // synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 3;
endpackage

// file: hw/tfs_pin_sync.sv
/*
  Three-stage pin synchroniser with agreement filter.
  Assumes the pin is asynchronous to clk; output changes only when stages
  two and three agree.
*/
`timescale 1ns/100ps
module tfs_pin_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // pin and filtered level
  input wire logic pin_in,
  output logic level_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // first stage is read only by the second
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // level moves only once two late stages agree, which filters metastable blips
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      level_out <= RST_VAL;
    end else if (s2_q == s3_q) begin
      level_out <= s3_q;
    end
  end
endmodule

// file: hw/tfs_status_bank.sv
/*
  Status and measurement register bank of a temperature-sensing fan controller.
  Assumes a serial-bus front end presents one-cycle read strobes with a byte
  address, and a measurement engine presents conditions as levels plus a
  one-cycle cycle_done pulse at the end of each monitoring cycle.
*/
// How it works
// RL1 - local low sets flag; read or alert clears
// RL2 - local high sets flag; read or alert clears
// RL3 - diode short or open sets error flag
// RL4 - remote alarm flag, cleared by primary read
// RL5 - remote low sets flag; read or alert clears
// RL6 - remote high sets flag; read or alert clears
// RL7 - full duty PWM sets a status flag
// RL8 - full duty rearms only after condition ends
// RL9 - external alarm line pull-down flag, read clears
// RL10 - local alarm flag; secondary low bits zero
// RL11 - both status registers zero after reset
// RL12 - fraction bits: local 7:5, remote 2:0
// RL13 - fan period byte, all ones at reset
// RL14 - stall when period count exceeds limit
// RL15 - integer temperature bytes held separately
// RL16 - clear after capture; same-cycle set wins
`timescale 1ns/100ps
module tfs_status_bank #(
  parameter int DATA_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // host read port
  input wire logic rd_stb,
  input wire logic [7:0] rd_addr,
  output logic [DATA_W-1:0] rd_data,
  output logic rd_valid,
  input wire logic alert_resp_done,
  // measurement engine inputs
  input wire logic cycle_done,
  input wire logic [DATA_W-1:0] local_temp,
  input wire logic [DATA_W-1:0] remote_temp,
  input wire logic [2:0] local_frac,
  input wire logic [2:0] remote_frac,
  input wire logic local_below_low,
  input wire logic local_above_high,
  input wire logic local_above_alarm,
  input wire logic remote_below_low,
  input wire logic remote_above_high,
  input wire logic remote_above_alarm,
  input wire logic diode_fault,
  input wire logic pwm_full_duty,
  input wire logic [DATA_W-1:0] tach_count,
  input wire logic [DATA_W-1:0] tach_limit,
  // alarm line pin as seen from the pad (low = pulled)
  input wire logic over_temp_alarm_line_in,
  // fan state
  output logic fan_stalled
);
  logic [DATA_W-1:0] status1_q;
  logic [DATA_W-1:0] status2_q;
  logic [DATA_W-1:0] frac_q;
  logic [DATA_W-1:0] fan_q;
  logic [DATA_W-1:0] ltemp_q;
  logic [DATA_W-1:0] rtemp_q;
  logic full_armed_q;
  logic line_level;
  logic rd_s1;
  logic rd_s2;
  logic alert_clr;
  logic [DATA_W-1:0] set1;
  logic [DATA_W-1:0] clr1;
  logic [DATA_W-1:0] set2;

  // pin passes four flops (three stages plus the filtered level) before it may raise a flag
  tfs_pin_sync #(
    .RST_VAL(1'b1)
  ) u_line_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(over_temp_alarm_line_in),
    .level_out(line_level)
  );

  // read strobes decoded per register
  assign rd_s1 = rd_stb && (rd_addr == tfs_pkg::OFS_STATUS_PRIMARY);
  assign rd_s2 = rd_stb && (rd_addr == tfs_pkg::OFS_STATUS_SECONDARY);
  assign alert_clr = alert_resp_done;

  // primary set terms, gated to monitoring cycle ends
  always_comb begin
    set1 = '0;
    set1[tfs_pkg::BIT_LOCAL_LOW] = cycle_done && local_below_low; // RL1
    set1[tfs_pkg::BIT_LOCAL_HIGH] = cycle_done && local_above_high; // RL2
    set1[tfs_pkg::BIT_DIODE_ERR] = cycle_done && diode_fault; // RL3
    set1[tfs_pkg::BIT_REMOTE_ALARM] = cycle_done && remote_above_alarm; // RL4
    set1[tfs_pkg::BIT_REMOTE_LOW] = cycle_done && remote_below_low; // RL5
    set1[tfs_pkg::BIT_REMOTE_HIGH] = cycle_done && remote_above_high; // RL6
    // one set per full-duty episode
    set1[tfs_pkg::BIT_FULL_DUTY] = cycle_done && pwm_full_duty && full_armed_q; // RL7
  end

  // primary clear terms: a read clears all, alert clears only window flags
  always_comb begin
    clr1 = {DATA_W{rd_s1}};
    clr1[tfs_pkg::BIT_LOCAL_LOW] = rd_s1 || alert_clr; // RL1
    clr1[tfs_pkg::BIT_LOCAL_HIGH] = rd_s1 || alert_clr; // RL2
    clr1[tfs_pkg::BIT_REMOTE_LOW] = rd_s1 || alert_clr; // RL5
    clr1[tfs_pkg::BIT_REMOTE_HIGH] = rd_s1 || alert_clr; // RL6
  end

  // secondary set terms; low six bits never set
  always_comb begin
    set2 = '0;
    set2[tfs_pkg::BIT_LINE_PULLED] = !line_level; // RL9
    set2[tfs_pkg::BIT_LOCAL_ALARM] = cycle_done && local_above_alarm; // RL10
  end

  // sticky flags; set beats clear so a same-cycle event is kept
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status1_q <= tfs_pkg::RST_STATUS; // RL11
      status2_q <= tfs_pkg::RST_STATUS; // RL11
    end else begin
      status1_q <= (status1_q & ~clr1) | set1; // RL16
      status2_q <= (status2_q & ~{DATA_W{rd_s2}}) | set2; // RL16
    end
  end

  // full-duty rearm: disarmed once flag is set, rearmed when condition ends
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      full_armed_q <= 1'b1;
    end else if (!pwm_full_duty) begin
      full_armed_q <= 1'b1; // RL8
    end else if (set1[tfs_pkg::BIT_FULL_DUTY]) begin
      full_armed_q <= 1'b0; // RL8
    end
  end

  // measurement bytes latched at each cycle end so a read sees a coherent set
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      frac_q <= tfs_pkg::RST_FRACTION;
      fan_q <= tfs_pkg::RST_FAN_PERIOD; // RL13
      ltemp_q <= tfs_pkg::RST_TEMP;
      rtemp_q <= tfs_pkg::RST_TEMP;
    end else if (cycle_done) begin
      frac_q <= '0;
      frac_q[tfs_pkg::FRAC_LOCAL_LSB +: tfs_pkg::FRAC_WIDTH] <= local_frac; // RL12
      frac_q[tfs_pkg::FRAC_REMOTE_LSB +: tfs_pkg::FRAC_WIDTH] <= remote_frac; // RL12
      fan_q <= tach_count; // RL13
      ltemp_q <= local_temp; // RL15
      rtemp_q <= remote_temp; // RL15
    end
  end

  // stall compare on the latched period; larger period means slower fan
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fan_stalled <= 1'b0;
    end else begin
      fan_stalled <= (fan_q > tach_limit); // RL14
    end
  end

  // read data captured from the pre-clear value in the strobe cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_stb;
      if (rd_stb) begin
        case (rd_addr)
          tfs_pkg::OFS_STATUS_PRIMARY: rd_data <= status1_q; // RL16
          tfs_pkg::OFS_STATUS_SECONDARY: rd_data <= status2_q; // RL16
          tfs_pkg::OFS_TEMP_FRACTION: rd_data <= frac_q;
          tfs_pkg::OFS_FAN_PERIOD: rd_data <= fan_q;
          tfs_pkg::OFS_LOCAL_TEMP: rd_data <= ltemp_q;
          tfs_pkg::OFS_REMOTE_TEMP: rd_data <= rtemp_q;
          default: rd_data <= '0;
        endcase
      end
    end
  end
endmodule

// file: testbench/tfs_status_chk_assertions.sv
/* assertions on the status bank ports
   assumes reads come from the host model, three cycles apart */
`timescale 1ns/100ps
module tfs_status_chk (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // read port
  input wire logic rd_stb,
  input wire logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic alert_resp_done,
  // engine, pin and stall
  input wire logic cycle_done,
  input wire logic local_below_low,
  input wire logic [7:0] tach_count,
  input wire logic [7:0] tach_limit,
  input wire logic over_temp_alarm_line_in,
  input wire logic fan_stalled
);
  // one domain, so clock and reset are given once
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_answer_next: assert property (rd_stb |=> rd_valid)
    else $error("read not answered");
  chk_answer_cause: assert property (rd_valid |-> $past(rd_stb))
    else $error("answer without read");
  // an alert response in the gap may clear the flag, so it is kept out
  chk_low_seen: assert property (cycle_done && local_below_low
    ##1 (!rd_stb && !alert_resp_done)[*2]
    ##1 rd_stb && rd_addr == 8'h02 |=> rd_data[7]) else $error("low flag lost");
  chk_read_clears: assert property (rd_stb && rd_addr == 8'h02 && !cycle_done
    ##1 (!rd_stb && !cycle_done)[*2] ##1 rd_stb && rd_addr == 8'h02
    |=> rd_data == 8'h00) else $error("flags kept after read");
  chk_alert_clears: assert property (alert_resp_done && !cycle_done
    ##1 (!rd_stb && !cycle_done)[*2] ##1 rd_stb && rd_addr == 8'h02
    |=> rd_data[7:6] == 2'b00 && rd_data[3:2] == 2'b00) else $error("alert left flags");
  chk_spare_zero: assert property (rd_valid && $past(rd_addr) == 8'h03
    |-> rd_data[5:0] == 6'h00) else $error("spare bits set");
  chk_line_flag: assert property ((!over_temp_alarm_line_in)[*7]
    ##0 rd_stb && rd_addr == 8'h03 |=> rd_data[7]) else $error("pulled line missed");
  // period latches one edge after the pulse, the compare flop one edge later
  chk_stall_cmp: assert property (cycle_done
    |-> ##2 fan_stalled == ($past(tach_count, 2) > $past(tach_limit)))
    else $error("stall wrong");
endmodule
bind tfs_status_bank tfs_status_chk i_chk (.clk(clk), .sys_rst(sys_rst), .rd_stb(rd_stb),
  .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .fan_stalled(fan_stalled),
  .alert_resp_done(alert_resp_done), .cycle_done(cycle_done), .tach_count(tach_count),
  .local_below_low(local_below_low), .tach_limit(tach_limit),
  .over_temp_alarm_line_in(over_temp_alarm_line_in));

// file: testbench/tfs_host_model.sv
/* host side reader feeding byte read strobes
   assumes the bench raises go for one cycle per read */
`timescale 1ns/100ps
module tfs_host_model (
  // clock
  input wire logic clk,
  // request from the bench
  input wire logic go,
  input wire logic [7:0] adr,
  // read port toward the bank
  output logic rd_stb = 1'b0,
  output logic [7:0] rd_addr = 8'h00
);
  // idle address toggles so a stale value is never trusted
  always @(posedge clk) begin
    rd_stb <= go;
    rd_addr <= go ? adr : ~rd_addr;
  end
endmodule

// file: testbench/tfs_status_bank_tb.sv
/* self-checking bench for the status bank
   assumes the bound checker and the host model */
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tfs_status_bank_tb;
  logic clk = 1'b0, sys_rst = 1'b1, go = 1'b0, cycle_done = 1'b0, alert = 1'b0, pin = 1'b1;
  logic [7:0] adr = 8'h00, cond = 8'h00, lt = 8'h00, rt = 8'h00, tc = 8'h00, tl = 8'hff;
  logic [2:0] lf = 3'h0, rf = 3'h0;
  logic rd_stb, rd_valid, fan_stalled;
  logic [7:0] rd_addr, rd_data;
  int err_count = 0, n_compared = 0, cycles = 0;
  tfs_host_model i_host (.clk(clk), .go(go), .adr(adr), .rd_stb(rd_stb), .rd_addr(rd_addr));
  tfs_status_bank i_dut (.clk(clk), .sys_rst(sys_rst), .rd_stb(rd_stb), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid), .alert_resp_done(alert), .cycle_done(cycle_done),
    .local_temp(lt), .remote_temp(rt), .local_frac(lf), .remote_frac(rf),
    .local_below_low(cond[7]), .local_above_high(cond[6]), .diode_fault(cond[5]),
    .remote_above_alarm(cond[4]), .remote_below_low(cond[3]), .remote_above_high(cond[2]),
    .pwm_full_duty(cond[1]), .local_above_alarm(cond[0]), .tach_count(tc), .tach_limit(tl),
    .over_temp_alarm_line_in(pin), .fan_stalled(fan_stalled));
  // clock, plus a ceiling well above the roughly 125 cycles needed
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles > 2000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one read through the host; answer lands exactly one cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) go <= 1'b1;
    adr <= a;
    @(posedge clk) go <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("valid", 1'b1, rd_valid)
    `CHK("data", e, rd_data)
  endtask
  task automatic cyc();
    @(posedge clk) cycle_done <= 1'b1;
    @(posedge clk) cycle_done <= 1'b0;
  endtask
  task automatic t_reset();
    rc(8'h02, 8'h00);
    rc(8'h03, 8'h00);
    rc(8'h06, 8'h00);
    rc(8'h08, 8'hff);
    rc(8'h20, 8'h00);
  endtask
  // full duty must stay down while held, then return after a break
  task automatic t_flags();
    @(posedge clk) cond <= 8'hfe;
    cyc();
    rc(8'h02, 8'hfe);
    rc(8'h02, 8'h00);
    cyc();
    rc(8'h02, 8'hfc);
    @(posedge clk) cond[1] <= 1'b0;
    cyc();
    @(posedge clk) cond[1] <= 1'b1;
    cyc();
    rc(8'h02, 8'hfe);
    @(posedge clk) cond <= 8'h00;
  endtask
  task automatic t_alert();
    @(posedge clk) cond <= 8'hfc;
    cyc();
    @(posedge clk) cond <= 8'h00;
    alert <= 1'b1;
    @(posedge clk) alert <= 1'b0;
    rc(8'h02, 8'h30);
  endtask
  task automatic t_sec();
    @(posedge clk) cond <= 8'h01;
    cyc();
    @(posedge clk) cond <= 8'h00;
    pin <= 1'b0;
    repeat (8) @(posedge clk);
    rc(8'h03, 8'hc0);
    @(posedge clk) pin <= 1'b1;
    repeat (8) @(posedge clk);
    rc(8'h03, 8'h80);
    rc(8'h03, 8'h00);
  endtask
  task automatic t_meas();
    @(posedge clk) {lf, rf, tc, tl, lt, rt} <= {3'h5, 3'h3, 32'h8040_2a55};
    cyc();
    rc(8'h06, 8'ha3);
    rc(8'h08, 8'h80);
    rc(8'h0a, 8'h2a);
    rc(8'h0b, 8'h55);
    `CHK("stall", 1'b1, fan_stalled)
    @(posedge clk) tl <= 8'h80;
    cyc();
    #1 `CHK("stall", 1'b0, fan_stalled)
  endtask
  // a set landing in the same cycle as a read or an alert must survive
  task automatic t_race();
    @(posedge clk) go <= 1'b1;
    adr <= 8'h02;
    cond <= 8'h80;
    @(posedge clk) go <= 1'b0;
    cycle_done <= 1'b1;
    @(posedge clk) cycle_done <= 1'b0;
    #1;
    `CHK("race data", 8'h00, rd_data)
    rc(8'h02, 8'h80);
    @(posedge clk) cycle_done <= 1'b1;
    alert <= 1'b1;
    @(posedge clk) cycle_done <= 1'b0;
    alert <= 1'b0;
    rc(8'h02, 8'h80);
    @(posedge clk) cond <= 8'h00;
  endtask
  // reset in mid-run must bring back the power-on values
  task automatic t_rerst();
    @(posedge clk) sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rc(8'h08, 8'hff);
    rc(8'h02, 8'h00);
    rc(8'h0a, 8'h1e);
    `CHK("stall", 1'b1, fan_stalled)
  endtask
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_flags();
    t_alert();
    t_sec();
    t_meas();
    t_race();
    t_rerst();
    give_verdict();
  end
endmodule
